//--- sfpe_regs.svh
// Constants of the serial flash program and erase engine
`ifndef SFPE_REGS_SVH
`define SFPE_REGS_SVH

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define SFPE_OP_LOAD_B1 8'h84
`define SFPE_OP_LOAD_B2 8'h87
`define SFPE_OP_EPROG_B1 8'h83
`define SFPE_OP_EPROG_B2 8'h86
`define SFPE_OP_PROG_B1 8'h88
`define SFPE_OP_PROG_B2 8'h89
`define SFPE_OP_PERASE 8'h81
`define SFPE_OP_BERASE 8'h50
`define SFPE_OP_THRU_B1 8'h82
`define SFPE_OP_THRU_B2 8'h85
`define SFPE_OP_XFER_B1 8'h53
`define SFPE_OP_XFER_B2 8'h55
`define SFPE_OP_CMP_B1 8'h60
`define SFPE_OP_CMP_B2 8'h61
`define SFPE_OP_REWR_B1 8'h58
`define SFPE_OP_REWR_B2 8'h59
`define SFPE_OP_STAT_A 8'h57
`define SFPE_OP_STAT_B 8'hd7

// ----------------------------------------
// Status register layout
// ----------------------------------------
`define SFPE_ST_READY 7
`define SFPE_ST_COMP 6
`define SFPE_ST_DENS_HI 5
`define SFPE_ST_DENS_LO 2
// Arbitrary neutral density code
`define SFPE_DENSITY 4'h5

// ----------------------------------------
// Frame layout in serial clock rises
// ----------------------------------------
`define SFPE_OPC_LAST 6'd7
`define SFPE_ADDR_LAST 6'd31
`define SFPE_BYTE_LAST 6'd39
`define SFPE_DATA_FIRST 6'd32
`define SFPE_BUF_BYTES 528
`define SFPE_FIFO_DEPTH 8

// ----------------------------------------
// Self-timed intervals
// ----------------------------------------
`define SFPE_CLK_NS 10
`define SFPE_EP_US 20
`define SFPE_PROG_US 14
`define SFPE_PE_US 8
`define SFPE_BE_US 12
`define SFPE_XFR_US 10
`define SFPE_US2CYC(us) (((us) * 1000) / `SFPE_CLK_NS)

`endif

//--- sfpe_pkg.sv
// Types of the serial flash program and erase engine
package sfpe_pkg;

  typedef enum logic [2:0] {
    SFPE_ST_IDLE,
    SFPE_ST_READ,
    SFPE_ST_ERASE,
    SFPE_ST_PROG,
    SFPE_ST_HOLD
  } sfpe_state_t;

  typedef enum logic [2:0] {
    SFPE_K_NONE,
    SFPE_K_XFER,
    SFPE_K_CMP,
    SFPE_K_EPROG,
    SFPE_K_PROG,
    SFPE_K_PERASE,
    SFPE_K_BERASE,
    SFPE_K_REWR
  } sfpe_kind_t;

  typedef struct packed {
    logic en;
    logic we;
    logic erase;
    logic block;
    logic [11:0] page;
    logic [9:0] col;
    logic [7:0] wdata;
  } sfpe_arr_req_t;

  typedef struct packed {
    logic buf_sel;
    logic [9:0] addr;
    logic [7:0] data;
  } sfpe_word_t;

endpackage

//--- sfpe_fifo.sv
// Parameterised valid/ready FIFO held in flip-flops
module sfpe_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  // Level flags
  output logic o_full,
  output logic o_empty
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_full = (count == (AW+1)'(DEPTH));
  assign o_empty = (count == '0);
  assign o_ready = !o_full;
  assign o_valid = !o_empty;
  assign o_data = mem[rd_idx];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_idx] <= i_data;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + AW'(1);
      if (pop)
        rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + AW'(1);
      if (push && !pop)
        count <= count + (AW+1)'(1);
      else if (pop && !push)
        count <= count - (AW+1)'(1);
    end
  end
endmodule

//--- sfpe_engine.sv
// Serial command front end and self-timed array sequencer of a two-buffer flash
// Notes on behaviour
// RULE1: status bit 7 is one when idle, zero during any self-timed operation.
// RULE2: with the serial clock parked low, output keeps showing the live ready bit.
// RULE3: status bit 6 holds the last compare result, one on any mismatch.
// RULE4: status bits 5..2 give a fixed density code; bits 1..0 undefined.
// RULE5: buffer load is 84H/87H, 14 don't-care bits, ten-bit start, then data.
// RULE6: loaded bytes advance the address, wrapping to zero, until select rises.
// RULE7: 83H/86H erase the page then program it from the buffer.
// RULE8: 88H/89H program the page from the buffer without erasing.
// RULE9: the host should avoid repeated programs of a page without erase.
// RULE10: 81H erases the addressed page to ones.
// RULE11: 50H erases the eight-page block picked by the upper page bits.
// RULE12: 82H/85H load the buffer, then erase and program the page.
// RULE13: 53H/55H copy the page into the buffer while busy.
// RULE14: 60H/61H compare 528 bytes, then update the compare bit.
// RULE15: 58H/59H copy the page to the buffer then erase and reprogram it.
// RULE16: the host holds select low through the command, then raises it.
// RULE17: the host rewrites each sector page within 10,000 sector operations.
// RULE18: busy covers transfer, compare, all programs and auto rewrite.
// RULE19: MSB first; input sampled on rising, output changed on falling edges.
// RULE20: status read 57H/D7H shifts status MSB first, repeating with fresh values.
// RULE21: the host starts no array operation while one is running.
// RULE22: first byte is the opcode; launch only on select rise after full command.
`include "sfpe_regs.svh"
module sfpe_engine #(
  parameter int BUF_BYTES = `SFPE_BUF_BYTES,
  parameter int FIFO_DEPTH = `SFPE_FIFO_DEPTH,
  parameter int EP_CYC = `SFPE_US2CYC(`SFPE_EP_US),
  parameter int PROG_CYC = `SFPE_US2CYC(`SFPE_PROG_US),
  parameter int PE_CYC = `SFPE_US2CYC(`SFPE_PE_US),
  parameter int BE_CYC = `SFPE_US2CYC(`SFPE_BE_US),
  parameter int XFR_CYC = `SFPE_US2CYC(`SFPE_XFR_US)
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Serial link
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // Open-drain ready pin
  output logic o_rdy_out,
  output logic o_rdy_oe,
  // Main array port
  output sfpe_pkg::sfpe_arr_req_t o_arr,
  input wire logic [7:0] i_arr_rdata,
  // Status view
  output logic [7:0] o_status
);
  import sfpe_pkg::*;

  // ----------------------------------------
  // Command decoding
  // ----------------------------------------
  function automatic sfpe_kind_t kind_of(input logic [7:0] opc);
    sfpe_kind_t k;
    k = SFPE_K_NONE;
    if (opc == `SFPE_OP_XFER_B1 || opc == `SFPE_OP_XFER_B2)
      k = SFPE_K_XFER;
    else if (opc == `SFPE_OP_CMP_B1 || opc == `SFPE_OP_CMP_B2)
      k = SFPE_K_CMP;
    else if (opc == `SFPE_OP_EPROG_B1 || opc == `SFPE_OP_EPROG_B2)
      k = SFPE_K_EPROG;
    // RULE12 through-buffer runs as erase-program
    else if (opc == `SFPE_OP_THRU_B1 || opc == `SFPE_OP_THRU_B2)
      k = SFPE_K_EPROG;
    else if (opc == `SFPE_OP_PROG_B1 || opc == `SFPE_OP_PROG_B2)
      k = SFPE_K_PROG;
    else if (opc == `SFPE_OP_PERASE)
      k = SFPE_K_PERASE;
    else if (opc == `SFPE_OP_BERASE)
      k = SFPE_K_BERASE;
    else if (opc == `SFPE_OP_REWR_B1 || opc == `SFPE_OP_REWR_B2)
      k = SFPE_K_REWR;
    return k;
  endfunction

  function automatic logic is_load(input logic [7:0] opc);
    return opc == `SFPE_OP_LOAD_B1 || opc == `SFPE_OP_LOAD_B2 ||
           opc == `SFPE_OP_THRU_B1 || opc == `SFPE_OP_THRU_B2;
  endfunction

  // Second buffer for the higher-valued member of each opcode pair
  function automatic logic buf_of(input logic [7:0] opc);
    return opc == `SFPE_OP_LOAD_B2 || opc == `SFPE_OP_EPROG_B2 ||
           opc == `SFPE_OP_PROG_B2 || opc == `SFPE_OP_THRU_B2 ||
           opc == `SFPE_OP_XFER_B2 || opc == `SFPE_OP_CMP_B2 ||
           opc == `SFPE_OP_REWR_B2;
  endfunction

  function automatic logic [23:0] time_of(input sfpe_kind_t k);
    logic [23:0] t;
    t = 24'(EP_CYC);
    if (k == SFPE_K_PROG)
      t = 24'(PROG_CYC);
    else if (k == SFPE_K_PERASE)
      t = 24'(PE_CYC);
    else if (k == SFPE_K_BERASE)
      t = 24'(BE_CYC);
    else if (k == SFPE_K_XFER || k == SFPE_K_CMP)
      t = 24'(XFR_CYC);
    return t;
  endfunction

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] cs_q;
  logic [2:0] sck_q;
  logic [1:0] si_q;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cs_q <= 3'h7;
      sck_q <= 3'h0;
      si_q <= 2'h0;
    end
    else
    begin
      cs_q <= {cs_q[1:0], i_cs_n};
      sck_q <= {sck_q[1:0], i_sck};
      si_q <= {si_q[0], i_si};
    end
  end

  logic sel;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign sel = !cs_q[1];
  assign cs_fall = !cs_q[1] && cs_q[2];
  assign cs_rise = cs_q[1] && !cs_q[2];
  // RULE19 rising edge samples
  assign sck_rise = sel && !cs_fall && sck_q[1] && !sck_q[2];
  assign sck_fall = sel && !sck_q[1] && sck_q[2];

  // ----------------------------------------
  // Serial shifter and command capture
  // ----------------------------------------
  logic [5:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] next_shreg;
  assign next_shreg = {shreg[6:0], si_q[1]};

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bit_cnt <= 6'h0;
      shreg <= 8'h0;
      opcode <= 8'h0;
      addr <= 24'h0;
    end
    else if (cs_fall)
      bit_cnt <= 6'h0;
    else if (sck_rise)
    begin
      shreg <= next_shreg;
      // RULE22 first byte is opcode
      if (bit_cnt == `SFPE_OPC_LAST)
        opcode <= next_shreg;
      if (bit_cnt > `SFPE_OPC_LAST && bit_cnt <= `SFPE_ADDR_LAST)
        addr <= {addr[22:0], si_q[1]};
      bit_cnt <= (bit_cnt == `SFPE_BYTE_LAST) ? `SFPE_DATA_FIRST : bit_cnt + 6'h1;
    end
  end

  // ----------------------------------------
  // Buffer load path through the FIFO
  // ----------------------------------------
  logic [9:0] wr_ptr;
  logic [9:0] start_raw;
  logic push_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_empty;
  logic drain;
  logic drain_ok;
  sfpe_word_t push_word;
  sfpe_word_t fw;

  assign start_raw = {addr[8:0], si_q[1]};
  // RULE5 data follows the 32-bit header
  assign push_valid = sck_rise && bit_cnt == `SFPE_BYTE_LAST && is_load(opcode);
  assign push_word = '{buf_sel: buf_of(opcode), addr: wr_ptr, data: next_shreg};

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      wr_ptr <= 10'h0;
    else if (sck_rise && bit_cnt == `SFPE_ADDR_LAST)
      wr_ptr <= (start_raw >= 10'(BUF_BYTES)) ? start_raw - 10'(BUF_BYTES) : start_raw;
    // RULE6 advance and wrap
    else if (push_valid)
      wr_ptr <= (wr_ptr == 10'(BUF_BYTES - 1)) ? 10'h0 : wr_ptr + 10'h1;
  end

  // A byte arriving while the FIFO is full is lost; drain stalls while the sequencer is not idle and the byte targets the operation's buffer
  sfpe_fifo #(
    .WIDTH($bits(sfpe_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_valid(push_valid),
    .o_ready(fifo_in_ready),
    .i_data(push_word),
    .o_valid(fifo_out_valid),
    .i_ready(drain_ok),
    .o_data(fw),
    .o_full(),
    .o_empty(fifo_empty)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  sfpe_state_t state;
  sfpe_kind_t kind;
  logic op_buf;
  logic [11:0] page;
  logic [9:0] idx;
  logic [9:0] rd_idx;
  logic rd_vld;
  logic [23:0] timer;
  logic pend;
  logic mism;
  logic comp;
  logic busy;
  logic launch;
  logic take;
  logic cmp_miss;
  logic idx_last;
  logic [7:0] buf_mem [2][BUF_BYTES];

  assign busy = state != SFPE_ST_IDLE || pend;
  // RULE22 launch only on select rise after a full header
  assign take = cs_rise && bit_cnt >= `SFPE_DATA_FIRST && kind_of(opcode) != SFPE_K_NONE && !busy;
  // Launch waits for queued load bytes to reach the buffer
  assign launch = pend && fifo_empty && state == SFPE_ST_IDLE;
  assign idx_last = idx == 10'(BUF_BYTES - 1);
  assign cmp_miss = rd_vld && kind == SFPE_K_CMP && buf_mem[op_buf][rd_idx] != i_arr_rdata;
  assign drain_ok = !(state != SFPE_ST_IDLE && fw.buf_sel == op_buf);
  assign drain = fifo_out_valid && drain_ok;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pend <= 1'b0;
      kind <= SFPE_K_NONE;
      op_buf <= 1'b0;
      page <= 12'h0;
    end
    else if (take)
    begin
      pend <= 1'b1;
      kind <= kind_of(opcode);
      op_buf <= buf_of(opcode);
      page <= addr[21:10];
    end
    else if (launch)
      pend <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= SFPE_ST_IDLE;
      idx <= 10'h0;
      timer <= 24'h0;
    end
    else
    begin
      timer <= (timer != 24'h0) ? timer - 24'h1 : 24'h0;
      case (state)
        SFPE_ST_IDLE:
        begin
          if (launch)
          begin
            timer <= time_of(kind);
            idx <= 10'h0;
            // RULE18 busy starts with every array operation
            if (kind == SFPE_K_XFER || kind == SFPE_K_CMP || kind == SFPE_K_REWR)
              state <= SFPE_ST_READ;
            else if (kind == SFPE_K_PROG)
              state <= SFPE_ST_PROG;
            else
              state <= SFPE_ST_ERASE;
          end
        end
        SFPE_ST_READ:
        begin
          idx <= idx_last ? 10'h0 : idx + 10'h1;
          // RULE15 copy first, then erase and program
          if (idx_last)
            state <= (kind == SFPE_K_REWR) ? SFPE_ST_ERASE : SFPE_ST_HOLD;
        end
        SFPE_ST_ERASE:
        begin
          // RULE10 single erase pulse
          // RULE7 erase precedes program
          state <= (kind == SFPE_K_EPROG || kind == SFPE_K_REWR) ? SFPE_ST_PROG : SFPE_ST_HOLD;
        end
        SFPE_ST_PROG:
        begin
          idx <= idx_last ? 10'h0 : idx + 10'h1;
          if (idx_last)
            state <= SFPE_ST_HOLD;
        end
        SFPE_ST_HOLD:
        begin
          if (timer == 24'h0)
            state <= SFPE_ST_IDLE;
        end
        default:
          state <= SFPE_ST_IDLE;
      endcase
    end
  end

  // RULE14 compare collects mismatches and posts them at completion
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_vld <= 1'b0;
      rd_idx <= 10'h0;
      mism <= 1'b0;
      comp <= 1'b0;
    end
    else
    begin
      rd_vld <= state == SFPE_ST_READ;
      rd_idx <= idx;
      if (launch)
        mism <= 1'b0;
      else if (cmp_miss)
        mism <= 1'b1;
      // RULE3 latest compare outcome
      if (state == SFPE_ST_HOLD && timer == 24'h0 && kind == SFPE_K_CMP)
        comp <= mism || cmp_miss;
    end
  end

  // RULE13 array bytes land in the buffer one cycle after the read
  always_ff @(posedge i_clk)
  begin
    if (drain)
      buf_mem[fw.buf_sel][fw.addr] <= fw.data;
    if (rd_vld && kind != SFPE_K_CMP)
      buf_mem[op_buf][rd_idx] <= i_arr_rdata;
  end

  // RULE8 program writes the buffer, no erase pulse
  // RULE11 block erase ignores the low three page bits
  always_comb
  begin
    o_arr = '0;
    o_arr.page = page;
    o_arr.col = idx;
    o_arr.wdata = buf_mem[op_buf][idx];
    o_arr.en = state == SFPE_ST_READ || state == SFPE_ST_ERASE || state == SFPE_ST_PROG;
    o_arr.we = state == SFPE_ST_PROG;
    o_arr.erase = state == SFPE_ST_ERASE;
    o_arr.block = state == SFPE_ST_ERASE && kind == SFPE_K_BERASE;
    if (o_arr.block)
      o_arr.page[2:0] = 3'h0;
  end

  // ----------------------------------------
  // Status and serial output
  // ----------------------------------------
  logic [7:0] status;
  logic stat_mode;
  logic stat_go;
  logic [2:0] stat_bit;

  // RULE1 ready bit
  // RULE4 density code, low bits zero
  assign status = {!busy, comp, `SFPE_DENSITY, 2'b00};

  // RULE20 status bits leave on falling edges, repeating
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stat_mode <= 1'b0;
      stat_go <= 1'b0;
      stat_bit <= 3'h7;
    end
    else if (!sel)
    begin
      stat_mode <= 1'b0;
      stat_go <= 1'b0;
    end
    else if (sck_rise && bit_cnt == `SFPE_OPC_LAST)
    begin
      stat_mode <= next_shreg == `SFPE_OP_STAT_A || next_shreg == `SFPE_OP_STAT_B;
      stat_bit <= 3'h7;
    end
    else if (sck_fall && stat_mode)
    begin
      if (stat_go)
        stat_bit <= stat_bit - 3'h1;
      stat_go <= 1'b1;
    end
  end

  // RULE2 output resampled every cycle so a parked clock shows live ready
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      o_status <= 8'h0;
      o_rdy_oe <= 1'b0;
    end
    else
    begin
      o_so <= stat_go && sel ? status[stat_bit] : 1'b0;
      o_so_oe <= stat_go && sel;
      o_status <= status;
      o_rdy_oe <= busy;
    end
  end
  assign o_rdy_out = 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_erase_then_prog;
    state == SFPE_ST_ERASE ##1 state == SFPE_ST_PROG;
  endsequence

  chk_ready_bit: assert property ($past(i_arst_n) |-> o_status[7] == !$past(busy)) // RULE1
    else $error("ready bit disagrees with busy");
  chk_so_live: assert property (stat_go && sel && $past(stat_go && sel) |-> o_so == $past(status[stat_bit])) // RULE2
    else $error("serial output not tracking live status");
  chk_comp_post: assert property (state == SFPE_ST_HOLD && timer == 0 && kind == SFPE_K_CMP |=> comp == $past(mism || cmp_miss)) // RULE3
    else $error("compare bit not updated at completion");
  chk_density_code: assert property (o_status[5:0] == {`SFPE_DENSITY, 2'b00} || !$past(i_arst_n)) // RULE4
    else $error("density field wrong");
  chk_wrap_addr: assert property (push_valid && wr_ptr == 10'(BUF_BYTES - 1) |=> wr_ptr == 10'h0) // RULE6
    else $error("load address failed to wrap");
  chk_fifo_room: assert property (push_valid |-> fifo_in_ready) // RULE6
    else $error("load byte arrived with the queue full");
  chk_erase_first: assert property (launch && kind == SFPE_K_EPROG |=> s_erase_then_prog) // RULE7
    else $error("erase-program order broken");
  chk_prog_noerase: assert property (launch && kind == SFPE_K_PROG |=> state == SFPE_ST_PROG ##1 !o_arr.erase) // RULE8
    else $error("plain program issued an erase");
  chk_block_align: assert property (o_arr.block |-> o_arr.erase && o_arr.page[2:0] == 3'h0) // RULE11
    else $error("block erase not aligned");
  chk_launch_rise: assert property ($rose(pend) |-> $past(cs_rise) && $past(bit_cnt) >= `SFPE_DATA_FIRST) // RULE22
    else $error("launch without select rise after header");
  chk_busy_walk: assert property (launch |=> busy [*8]) // RULE18
    else $error("busy dropped during operation");
endmodule

//--- sfpe_host.sv
// Behavioural host serial master that drives the engine's link pins
module sfpe_host (
  // Clock
  input wire logic i_clk,
  // Link pins
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b1;
  end

  // ---
  // Link timing
  // ---
  // Half link period of four system clocks gives the 80 ns link clock
  task automatic half();
    repeat (4) @(posedge i_clk);
    #1;
  endtask

  // MSB first, data set while clock low
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      o_sck = 1'b0;
      o_si = b[i];
      half();
      o_sck = 1'b1;
      half();
    end
  endtask

  task automatic sel();
    o_cs_n = 1'b0;
    half();
  endtask

  // Released data line shows the inverse, so a stale bit never passes
  task automatic desel();
    half();
    o_cs_n = 1'b1;
    o_si = ~o_si;
    half();
  endtask

  // ---
  // Frames
  // ---
  // select held low over opcode, reserved bits, page, column and data
  task automatic cmd(input logic [7:0] op, input logic [11:0] pg, input logic [9:0] col, input logic [7:0] d[$]);
    sel();
    put(op);
    put({2'b00, pg[11:6]});
    put({pg[5:0], col[9:8]});
    put(col[7:0]);
    foreach (d[i]) put(d[i]);
    desel();
  endtask

  // park on the ready bit; no new array command until it rises
  task automatic stat(input logic [7:0] op, output logic [7:0] st, output int wc);
    sel();
    put(op);
    for (int i = 7; i >= 0; i--)
    begin
      o_sck = 1'b0;
      half();
      o_sck = 1'b1;
      half();
      st[i] = i_so;
    end
    o_sck = 1'b0;
    half();
    half();
    wc = 0;
    while (i_so !== 1'b1 && wc < 20000)
    begin
      @(posedge i_clk);
      #1;
      wc++;
    end
    desel();
  endtask
endmodule

//--- test_sfpe_engine.sv
// Self-checking bench of the serial flash program and erase engine
`include "sfpe_regs.svh"
module test_sfpe_engine;
  timeunit 1ns;
  timeprecision 1ns;
  import sfpe_pkg::*;

  logic i_clk, i_arst_n, cs_n, sck, si, so, so_oe, rdy_out, rdy_oe, comp;
  sfpe_arr_req_t arr;
  logic [7:0] rdata, status, st;
  logic [7:0] mem [int];
  logic [7:0] q[$];
  logic [7:0] sop [2] = '{8'h57, 8'hd7};
  int miscompares, compares, ers, wc;

  sfpe_engine #(.EP_CYC(50), .PROG_CYC(50), .XFR_CYC(50)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .o_rdy_out(rdy_out), .o_rdy_oe(rdy_oe), .o_arr(arr), .i_arr_rdata(rdata),
    .o_status(status));

  sfpe_host host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ---
  // Main array model, erased bytes read as ones
  // ---
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  always @(posedge i_clk)
  begin
    rdata <= rd(arr.page * 528 + arr.col);
    if (arr.en && arr.erase)
    begin
      ers++;
      for (int a = arr.page * 528; a < (arr.page + (arr.block ? 8 : 1)) * 528; a++) mem.delete(a);
    end
    else if (arr.en && arr.we)
      mem[arr.page * 528 + arr.col] = rd(arr.page * 528 + arr.col) & arr.wdata;
  end

  // ---
  // Checking
  // ---
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One array command, a busy status read, a parked ready wait and one array byte
  task automatic run(input logic [7:0] op, input int pg, input int col, input logic c, input int de, input int a,
                     input logic [7:0] v);
    int e0;
    e0 = ers;
    host.cmd(op, pg[11:0], col[9:0], q);
    q = {};
    check("busy pin", {rdy_oe, rdy_out}, 2'b10);
    host.stat(8'hd7, st, wc);
    check("busy status", st[7:2], {1'b0, comp, `SFPE_DENSITY});
    check("ready wait", wc < 20000, 1'b1);
    comp = c;
    check("ready status", status, {1'b1, comp, `SFPE_DENSITY, 2'b00});
    check("ready pin", rdy_oe, 1'b0);
    check("erase count", ers - e0, de);
    check("array byte", rd(a), v);
  endtask

  // ---
  // Tests
  // ---
  initial
  begin
    compares = 0;
    miscompares = 0;
    comp = 1'b0;
    i_arst_n = 1'b0;
    repeat (6) @(posedge i_clk);
    #1;
    i_arst_n = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    check("reset status", status, {2'b10, `SFPE_DENSITY, 2'b00});
    foreach (sop[i])
    begin
      host.stat(sop[i], st, wc);
      check("idle status", st[7:2], {2'b10, `SFPE_DENSITY});
      check("output enable", so_oe, 1'b0);
    end
    run(8'h53, 100, 0, 0, 0, 100 * 528, 8'hff);
    run(8'h55, 100, 0, 0, 0, 100 * 528, 8'hff);
    q = {8'ha5, 8'h3c};
    host.cmd(8'h84, 12'h000, 10'd527, q);
    q = {};
    run(8'h83, 5, 0, 0, 1, 5 * 528 + 527, 8'ha5);
    check("wrapped byte", rd(5 * 528), 8'h3c);
    check("erased byte", rd(5 * 528 + 1), 8'hff);
    run(8'h61, 5, 0, 1, 0, 5 * 528, 8'h3c);
    run(8'h60, 5, 0, 0, 0, 5 * 528, 8'h3c);
    mem[20 * 528 + 527] = 8'h0f;
    run(8'h88, 20, 0, 0, 0, 20 * 528 + 527, 8'h05);
    run(8'h89, 21, 0, 0, 0, 21 * 528 + 527, 8'hff);
    run(8'h86, 20, 0, 0, 1, 20 * 528 + 527, 8'hff);
    run(8'h81, 5, 0, 0, 1, 5 * 528 + 527, 8'hff);
    mem[9 * 528] = 8'h00;
    mem[15 * 528 + 527] = 8'h00;
    mem[16 * 528] = 8'h00;
    run(8'h50, 13, 0, 0, 1, 9 * 528, 8'hff);
    check("block end", rd(15 * 528 + 527), 8'hff);
    check("next block", rd(16 * 528), 8'h00);
    q = {8'h5a};
    run(8'h82, 30, 3, 0, 1, 30 * 528 + 3, 8'h5a);
    run(8'h58, 30, 0, 0, 1, 30 * 528 + 527, 8'ha5);
    run(8'h59, 30, 0, 0, 1, 30 * 528 + 3, 8'h5a);
    run(8'h61, 30, 0, 0, 0, 30 * 528, 8'h3c);
    q = {8'h00};
    host.cmd(8'h87, 12'h000, 10'd3, q);
    q = {};
    run(8'h61, 30, 0, 1, 0, 30 * 528 + 3, 8'h5a);
    q = {8'h77};
    run(8'h85, 40, 10, 1, 1, 40 * 528 + 10, 8'h77);
    check("second buffer", rd(40 * 528 + 3), 8'h00);
    // Cut-short frame must not launch anything
    host.sel();
    host.put(8'h81);
    host.put(8'h00);
    host.desel();
    repeat (20) @(posedge i_clk);
    #1;
    check("short frame", status[7], 1'b1);
    test_done();
  end

  initial
  begin
    #900000;
    miscompares++;
    test_done();
  end
endmodule
